/* File: inc/fcs_pkg.sv */
// Notes on behaviour
// - Outputs alternate floor and ceiling divide ratios
// - Phase error tracked and corrected each edge
// - Output rate equals ref times N over PM
// - Dividers: 10-bit integer, 30-bit num/den
// - Four independent output dividers from VCO
// - Each output set independently, 1-200 MHz
// - Reset copies OTP store into working registers
// - OTP store programmable once only
// - Host changes working registers; device applies them
// - Single output change leaves others undisturbed
// - Reconfigured divider loses alignment until realign
// - Soft reset realigns, outputs off meanwhile
package fcs_pkg;
    // *************************************************
    // Widths and layout
    // *************************************************
    localparam int INT_W    = 10;
    localparam int FRAC_W   = 30;
    localparam int NUM_OUT  = 4;
    localparam int NUM_DIV  = 5;           // 4 outputs + feedback
    localparam int FB_IDX   = 4;
    localparam int BYTES    = 9;           // 10+30+30 bits -> 9 bytes
    localparam int BYTE_W   = 4;           // byte index width
    localparam int SEL_W    = 3;
    localparam int ACC_W    = 31;
    localparam int CNT_W    = 11;
    localparam logic [8:0] ALL_BYTES = 9'h1FF;
    localparam int REALIGN_CYC = 16;       // outputs off during realign
    localparam logic [4:0] REALIGN_LAST = 5'(REALIGN_CYC - 1);

    // Integer part plus numerator over denominator
    typedef struct packed {
        logic [INT_W-1:0]  int_part;
        logic [FRAC_W-1:0] num;
        logic [FRAC_W-1:0] den;
    } fcs_ratio_s;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_RUN, ST_ALIGN}
        fcs_state_e;
endpackage

/* File: src/fcs_config.sv */
`timescale 1ns/1ns
module fcs_config
    import fcs_pkg::*;
(
    input  wire logic                       sys_clk_i,     // System clock
    input  wire logic                       arst_n_i,      // Async reset
    input  wire logic                       vco_clk_en_i,  // VCO tick
    input  wire logic [NUM_DIV*72-1:0]      otp_image_i,   // OTP contents
    input  wire logic                       otp_blank_i,   // OTP unused
    input  wire logic                       otp_prog_i,    // Burn request
    input  wire logic                       wr_en_i,       // Byte write
    input  wire logic [SEL_W-1:0]           wr_sel_i,      // Divider select
    input  wire logic [BYTE_W-1:0]          wr_byte_i,     // Byte index
    input  wire logic [7:0]                 wr_data_i,     // Byte data
    input  wire logic [NUM_OUT-1:0]         out_en_i,      // Output enables
    input  wire logic                       soft_reset_i,  // Realign cmd
    output logic [NUM_OUT-1:0]              clk_o,         // Output clocks
    output logic [NUM_OUT-1:0]              aligned_o,     // Skew aligned
    output logic                            otp_burnt_o,   // OTP written
    output logic                            ready_o        // Config loaded
);
    // *************************************************
    // Storage
    // *************************************************
    fcs_state_e           state_q;
    logic [71:0]          otp_q   [NUM_DIV];
    logic [71:0]          stage_q [NUM_DIV];
    logic [8:0]           seen_q  [NUM_DIV];
    fcs_ratio_s           act_q   [NUM_DIV];
    logic [CNT_W-1:0]     cnt_q   [NUM_OUT];
    logic [ACC_W-1:0]     acc_q   [NUM_OUT];
    logic [NUM_OUT-1:0]   tog_q;
    logic [4:0]           align_q;
    logic [NUM_DIV-1:0]   commit;
    logic                 burnt_q;

    // Pending ratio complete when all 9 bytes written
    function automatic logic full(input logic [8:0] s);
        return s == ALL_BYTES;
    endfunction

    always_comb begin
        for (int d = 0; d < NUM_DIV; d++) begin
            commit[d] = (state_q == ST_RUN) && full(seen_q[d]);
        end
    end

    // *************************************************
    // Load sequence and realignment
    // *************************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= ST_IDLE;
            align_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= ST_LOAD;
                ST_LOAD: state_q <= ST_RUN;
                ST_RUN: begin
                    if (soft_reset_i) begin
                        state_q <= ST_ALIGN;
                        align_q <= '0;
                    end
                end
                ST_ALIGN: begin
                    align_q <= align_q + 5'h01;
                    if (align_q == REALIGN_LAST) state_q <= ST_RUN;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // One-time store: burns once from the working set
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            burnt_q <= 1'b0;
            for (int d = 0; d < NUM_DIV; d++) otp_q[d] <= '0;
        end else if (state_q == ST_IDLE) begin
            burnt_q <= !otp_blank_i;
            for (int d = 0; d < NUM_DIV; d++)
                otp_q[d] <= otp_image_i[d*72 +: 72];
        end else if (otp_prog_i && !burnt_q) begin
            burnt_q <= 1'b1;
            for (int d = 0; d < NUM_DIV; d++)
                otp_q[d] <= {2'b00, act_q[d]};
        end
    end

    // Byte staging; a divider byte set commits atomically
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int d = 0; d < NUM_DIV; d++) begin
                stage_q[d] <= '0;
                seen_q[d]  <= '0;
            end
        end else begin
            for (int d = 0; d < NUM_DIV; d++) begin
                if (commit[d]) seen_q[d] <= '0;
                if (wr_en_i && state_q == ST_RUN && wr_sel_i == SEL_W'(d)
                    && wr_byte_i < BYTE_W'(BYTES)) begin
                    stage_q[d][wr_byte_i*8 +: 8] <= wr_data_i;
                    seen_q[d][wr_byte_i] <= 1'b1;
                end
            end
        end
    end

    // Active ratios: OTP copy at load, then full commits only
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int d = 0; d < NUM_DIV; d++) act_q[d] <= '0;
        end else begin
            for (int d = 0; d < NUM_DIV; d++) begin
                if (state_q == ST_LOAD)
                    act_q[d] <= fcs_ratio_s'(otp_q[d][69:0]);
                else if (commit[d])
                    act_q[d] <= fcs_ratio_s'(stage_q[d][69:0]);
            end
        end
    end

    // *************************************************
    // Fractional output dividers
    // *************************************************
    // Frequency is set by the pair of counts chosen; the feedback
    // ratio is not used here, and the VCO tick is supplied from outside.
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int o = 0; o < NUM_OUT; o++) begin
                cnt_q[o] <= '0;
                acc_q[o] <= '0;
            end
            tog_q <= '0;
        end else begin
            for (int o = 0; o < NUM_OUT; o++) begin
                if (state_q != ST_RUN || commit[o]) begin
                    cnt_q[o] <= '0;
                    acc_q[o] <= '0;
                    tog_q[o] <= 1'b0;
                end else if (vco_clk_en_i) begin
                    if (cnt_q[o] + CNT_W'(1) >=
                        {1'b0, act_q[o].int_part} +
                        CNT_W'(acc_q[o] + {1'b0, act_q[o].num}
                               >= {1'b0, act_q[o].den}
                               && act_q[o].den != '0)) begin
                        cnt_q[o] <= '0;
                        tog_q[o] <= ~tog_q[o];
                        // Phase error residue carried to next cycle
                        if (act_q[o].den != '0 &&
                            acc_q[o] + {1'b0, act_q[o].num}
                            >= {1'b0, act_q[o].den})
                            acc_q[o] <= acc_q[o] + {1'b0, act_q[o].num}
                                        - {1'b0, act_q[o].den};
                        else
                            acc_q[o] <= acc_q[o] + {1'b0, act_q[o].num};
                    end else begin
                        cnt_q[o] <= cnt_q[o] + CNT_W'(1);
                    end
                end
            end
        end
    end

    // *************************************************
    // Outputs
    // *************************************************
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            clk_o       <= '0;
            aligned_o   <= '0;
            otp_burnt_o <= 1'b0;
            ready_o     <= 1'b0;
        end else begin
            // All off during realign independent enables
            clk_o       <= (state_q == ST_RUN) ? (tog_q & out_en_i) : '0;
            otp_burnt_o <= burnt_q;
            ready_o     <= (state_q == ST_RUN);
            for (int o = 0; o < NUM_OUT; o++) begin
                if (state_q == ST_LOAD || state_q == ST_ALIGN)
                    aligned_o[o] <= 1'b1;
                else if (commit[o])
                    aligned_o[o] <= 1'b0;
            end
        end
    end

    // *************************************************
    // Checks
    // *************************************************
    // Any output that takes a new ratio drops its aligned flag
    property p_commit_clears_align;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (commit[NUM_OUT-1:0] != '0) |=>
            ((aligned_o & $past(commit[NUM_OUT-1:0])) == '0);
    endproperty
    a_commit_clears_align: assert property (p_commit_clears_align)
        else $error("aligned flag kept after divider change");

    property p_align_off;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        state_q == ST_ALIGN |=> clk_o == '0;
    endproperty
    a_align_off: assert property (p_align_off)
        else $error("output active during realign");

    property p_partial_no_apply;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_q == ST_RUN && !full(seen_q[1])) |=> $stable(act_q[1]);
    endproperty
    a_partial_no_apply: assert property (p_partial_no_apply)
        else $error("partial ratio applied");

    property p_otp_once;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (burnt_q && state_q != ST_IDLE) |=> $stable(otp_q[0]);
    endproperty
    a_otp_once: assert property (p_otp_once)
        else $error("OTP store rewritten");

    // Realign window: sixteen cycles, then all flags back up
    sequence s_realign_hold;
        (state_q == ST_ALIGN) ##15 (state_q == ST_ALIGN);
    endsequence
    sequence s_realign_exit;
        (state_q == ST_RUN) && (aligned_o == '1);
    endsequence
    property p_realign_steps;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (state_q == ST_RUN && soft_reset_i) |=>
            s_realign_hold ##1 s_realign_exit;
    endproperty
    a_realign_steps: assert property (p_realign_steps)
        else $error("realign sequence out of step");

    // Load step copies the stored ratio into the working set
    property p_load_copy;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        state_q == ST_LOAD |=>
            act_q[0] == fcs_ratio_s'($past(otp_q[0][69:0]));
    endproperty
    a_load_copy: assert property (p_load_copy)
        else $error("stored ratio not copied at load");
endmodule // fcs_config

/* File: verif/fcs_host_model.sv */
`timescale 1ns/1ns
module fcs_host_model
    import fcs_pkg::*;
(
    input  wire logic          sys_clk_i, // System clock
    output logic               wr_en_o,   // Byte write
    output logic [SEL_W-1:0]   wr_sel_o,  // Divider select
    output logic [BYTE_W-1:0]  wr_byte_o, // Byte index
    output logic [7:0]         wr_data_o  // Byte data
);
    // ****************************
    // Host byte writer
    // ****************************
    // Quiet bus at time zero
    initial begin
        wr_en_o   = 1'b0;
        wr_sel_o  = '0;
        wr_byte_o = '0;
        wr_data_o = 8'h00;
    end
    // Whole bytes, one per cycle, changed on the falling edge
    task automatic put_ratio(input logic [SEL_W-1:0] sel,
                             input fcs_ratio_s r, input int n);
        logic [71:0] w;
        w = {2'b00, r};
        for (int b = 0; b < n; b++) begin
            @(negedge sys_clk_i);
            wr_en_o   <= 1'b1;
            wr_sel_o  <= sel;
            wr_byte_o <= BYTE_W'(b);
            wr_data_o <= w[b*8+:8];
        end
        @(negedge sys_clk_i);
        wr_en_o   <= 1'b0;
        wr_data_o <= ~wr_data_o; // Released data never looks stale
    endtask
endmodule // fcs_host_model

/* File: verif/fractional_clock_synth_config_tb_top.sv */
`timescale 1ns/1ns
module fractional_clock_synth_config_tb_top
    import fcs_pkg::*;
;
    localparam logic [359:0] OTP_IMG =
        {{4{2'b00, 10'h004, 60'h0}}, 2'b00, 10'h002, 60'h0};
    logic               sys_clk_i = 1'b0;  // System clock
    logic               arst_n_i  = 1'b0;  // Async reset
    logic               otp_prog_i = 1'b0; // Burn request
    logic               soft_reset_i = 1'b0; // Realign
    logic [NUM_OUT-1:0] out_en_i = 4'hF;   // Output enables
    logic               otp_blank_i = 1'b1; // Store not yet burnt
    logic               vco_en_i = 1'b1;   // VCO tick
    logic               wr_en, otp_burnt_o, ready_o;
    logic [SEL_W-1:0]   wr_sel;
    logic [BYTE_W-1:0]  wr_byte;
    logic [7:0]         wr_data;
    logic [NUM_OUT-1:0] clk_o, aligned_o;
    int                 failures = 0;
    int                 checked = 0;
    int                 n;
    // 125 MHz clock
    always #4 sys_clk_i = ~sys_clk_i;
    fcs_host_model host (.sys_clk_i(sys_clk_i), .wr_en_o(wr_en),
        .wr_sel_o(wr_sel), .wr_byte_o(wr_byte), .wr_data_o(wr_data));
    fcs_config dut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
        .vco_clk_en_i(vco_en_i), .otp_image_i(OTP_IMG),
        .otp_blank_i(otp_blank_i),
        .otp_prog_i(otp_prog_i), .wr_en_i(wr_en), .wr_sel_i(wr_sel),
        .wr_byte_i(wr_byte), .wr_data_i(wr_data), .out_en_i(out_en_i),
        .soft_reset_i(soft_reset_i), .clk_o(clk_o), .aligned_o(aligned_o),
        .otp_burnt_o(otp_burnt_o), .ready_o(ready_o));
    // ****************************
    // Shared helpers
    // ****************************
    task automatic compare_val(input logic [31:0] got, input logic [31:0] e);
        checked++;
        if (got !== e) begin
            failures++;
            $display("Error at %0t: got %0h expected %0h", $time, got, e);
        end
    endtask
    // Edges seen on one output over a window of cycles
    task automatic count_chg(input int idx, input int cyc, output int c);
        logic prev;
        c = 0;
        @(negedge sys_clk_i);
        prev = clk_o[idx];
        repeat (cyc) begin
            @(negedge sys_clk_i);
            if (clk_o[idx] !== prev) c++;
            prev = clk_o[idx];
        end
    endtask
    task automatic complete_run;
        $display("Checked %0d, failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_reset;
        repeat (3) @(negedge sys_clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(posedge sys_clk_i);
        #1 compare_val(32'(ready_o), 32'h1);
        compare_val(32'(otp_burnt_o), 32'h0);
        count_chg(0, 40, n);
        compare_val(n, 32'h14);
    endtask
    // Half-rate VCO ticks halve the output rate; 40 toggles end high
    task automatic t_rate;
        logic prev;
        n = 0;
        prev = clk_o[0];
        repeat (40) begin
            @(negedge sys_clk_i);
            vco_en_i = ~vco_en_i;
            if (clk_o[0] !== prev) n++;
            prev = clk_o[0];
        end
        compare_val(32'(n inside {[9:11]}), 32'h1);
    endtask
    // Partial write must not apply; full write retunes one output
    task automatic t_write;
        host.put_ratio(3'h2, '{int_part: 10'h005, num: '0, den: '0}, 8);
        repeat (3) @(negedge sys_clk_i);
        compare_val(32'(aligned_o[2]), 32'h1);
        count_chg(2, 40, n);
        compare_val(n, 32'h0A);
        out_en_i[1] = 1'b0;
        host.put_ratio(3'h1, '{int_part: 10'h003, num: '0, den: '0},
                       9);
        count_chg(1, 10, n);
        compare_val(n, 32'h0);
        out_en_i[1] = 1'b1;
        compare_val(32'(aligned_o[1]), 32'h0);
        count_chg(1, 60, n);
        compare_val(n, 32'h14);
        count_chg(0, 40, n);
        compare_val(n, 32'h14);
    endtask
    // Ratio 2.5 alternates 2 and 3 ticks per half period
    task automatic t_frac;
        host.put_ratio(3'h3, '{int_part: 10'h002, num: 30'h1, den: 30'h2}, 9);
        repeat (3) @(negedge sys_clk_i);
        count_chg(3, 100, n);
        compare_val(32'(n inside {[39:41]}), 32'h1);
    endtask
    task automatic t_align;
        logic [NUM_OUT-1:0] seen;
        seen = '0;
        soft_reset_i = 1'b1;
        @(negedge sys_clk_i);
        soft_reset_i = 1'b0;
        repeat (16) begin
            @(negedge sys_clk_i);
            seen = seen | clk_o;
        end
        compare_val(32'(seen), 32'h0);
        compare_val(32'(aligned_o), 32'hF);
        count_chg(0, 40, n);
        compare_val(n, 32'h14);
    endtask
    // Mid-run reset with a burnt store: image reloads, flag reads burnt
    task automatic t_rearm;
        otp_blank_i = 1'b0;
        arst_n_i = 1'b0;
        repeat (3) @(negedge sys_clk_i);
        compare_val(32'(ready_o), 32'h0);
        arst_n_i = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        compare_val(32'(ready_o), 32'h1);
        compare_val(32'(otp_burnt_o), 32'h1);
        count_chg(1, 40, n);
        compare_val(n, 32'h0A);
    endtask
    task automatic t_otp;
        repeat (2) begin
            otp_prog_i = 1'b1;
            @(negedge sys_clk_i);
            otp_prog_i = 1'b0;
            repeat (2) @(negedge sys_clk_i);
            compare_val(32'(otp_burnt_o), 32'h1);
        end
    endtask
    // Main sequence
    initial begin
        t_reset();
        t_rate();
        t_write();
        t_frac();
        t_align();
        t_otp();
        t_rearm();
        complete_run();
    end
    // Watchdog well past the expected run length
    initial begin
        #40000;
        failures++;
        complete_run();
    end
endmodule // fractional_clock_synth_config_tb_top
